// ===== sdram_sleep_entry_sequencer.sv
// Sleep entry sequencer: refresh, bank, clock enable and sleep control
`timescale 1ns/1ps
`default_nettype none
`include "sleep_seq_map.svh"
// How it works
// - Software bit or high fault requests sleep
// - Zero interval field stops refresh
// - Bit 31 commands self-refresh
// - Clearing bank enable bits disables banks
// - Clearing bits 31,20 drops clock enable
// - Force-sleep bit enters sleep
// - Fault enters or holds sleep after release
// - Software flag only for force-sleep entry
// - Separate hard and sleep reset flags
module sdram_sleep_entry_sequencer
(
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_refr_we,
  input  wire logic [31:0] i_refr_wdata,
  input  wire logic        i_cfg_we,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic        i_pmc_we,
  input  wire logic [31:0] i_pmc_wdata,
  input  wire logic        i_battery_fault_input,
  input  wire logic        i_supply_fault_input,
  input  wire logic        i_access_busy,
  input  wire logic        i_wake,
  input  wire logic        i_status_clear,
  output logic [31:0]      o_dram_refresh_control,
  output logic [31:0]      o_dram_config_register,
  output logic             o_refresh_enable,
  output logic             o_sdram_clock_enable,
  output logic             o_precharge_all,
  output logic             o_self_refresh_cmd,
  output logic             o_sleep,
  output logic             o_software_sleep_flag,
  output logic             o_hard_reset_flag,
  output logic             o_sleep_wake_reset_flag
);
  sleep_seq_pkg::seq_state_t state_ff;
  sleep_seq_pkg::seq_state_t nxt_state;
  logic [3:0]  pre_cnt_ff;
  logic [3:0]  nxt_pre_cnt;
  logic        sw_entry_ff;
  logic        sw_sleep_ff;
  logic        batt_sync;
  logic        supply_sync;
  logic        fault_any;
  logic        ce_released;
  logic        sleep_req;
  logic        sw_req;
  logic [31:0] nxt_refr;
  logic [31:0] nxt_cfg;
  logic        in_sleep;

  // Fault pins arrive from outside the clock domain
  sync_two_ff u_sync_batt
  (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_battery_fault_input),
    .o_sync    (batt_sync)
  );
  sync_two_ff u_sync_supply
  (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_supply_fault_input),
    .o_sync    (supply_sync)
  );

  // Request decode
  assign fault_any   = batt_sync | supply_sync;
  assign sw_req      = i_pmc_we & i_pmc_wdata[`PMC_FORCE_SLEEP_BIT];
  assign ce_released = ~o_dram_refresh_control[`REFR_CLOCK_ENABLE_BIT]
                     & ~o_dram_refresh_control[`REFR_SELF_REFRESH_BIT];
  assign sleep_req   = sw_req | fault_any;
  assign in_sleep    = (state_ff == sleep_seq_pkg::ST_SLEEP);

  // Register writes store whole words; software keeps other bits
  assign nxt_refr = i_refr_we ? i_refr_wdata : o_dram_refresh_control;
  assign nxt_cfg  = i_cfg_we ? i_cfg_wdata : o_dram_config_register;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_dram_refresh_control <= `REFR_RESET_VALUE;
      o_dram_config_register <= `CFG_RESET_VALUE;
    end
    else
    begin
      o_dram_refresh_control <= nxt_refr;
      o_dram_config_register <= nxt_cfg;
    end
  end

  // Sequence: finish access, precharge, self-refresh, sleep
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_pre_cnt = pre_cnt_ff;
    case (state_ff)
      sleep_seq_pkg::ST_RUN:
        if (sleep_req)
        begin
          nxt_state = sleep_seq_pkg::ST_DRAIN;
        end
      sleep_seq_pkg::ST_DRAIN:
        if (!i_access_busy)
        begin
          nxt_state   = sleep_seq_pkg::ST_PRECHARGE;
          nxt_pre_cnt = `PRECHARGE_CYCLES;
        end
      sleep_seq_pkg::ST_PRECHARGE:
        if (pre_cnt_ff == 4'h0)
        begin
          nxt_state = sleep_seq_pkg::ST_SELF_REF;
        end
        else
        begin
          nxt_pre_cnt = pre_cnt_ff - 4'h1;
        end
      sleep_seq_pkg::ST_SELF_REF:
        nxt_state = sleep_seq_pkg::ST_SLEEP;
      sleep_seq_pkg::ST_SLEEP:
        // A high fault holds sleep over a wake
        if (i_wake && !fault_any)
        begin
          nxt_state = sleep_seq_pkg::ST_RUN;
        end
      default:
        nxt_state = sleep_seq_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      state_ff   <= sleep_seq_pkg::ST_RUN;
      pre_cnt_ff <= 4'h0;
    end
    else
    begin
      state_ff   <= nxt_state;
      pre_cnt_ff <= nxt_pre_cnt;
    end
  end

  // Remember how this entry began; fault wins if both arrive together
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      sw_entry_ff <= 1'b0;
    end
    else if (state_ff == sleep_seq_pkg::ST_RUN && sleep_req)
    begin
      sw_entry_ff <= sw_req & ~fault_any;
    end
  end

  // Memory side outputs, all registered
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_refresh_enable     <= 1'b0;
      o_sdram_clock_enable <= 1'b0;
      o_precharge_all      <= 1'b0;
      o_self_refresh_cmd   <= 1'b0;
      o_sleep              <= 1'b0;
    end
    else
    begin
      o_refresh_enable <= (|nxt_refr[`REFR_INTERVAL_HI:`REFR_INTERVAL_LO])
                        & (nxt_state == sleep_seq_pkg::ST_RUN);
      // Clock enable held low once released or asleep
      o_sdram_clock_enable <= nxt_refr[`REFR_CLOCK_ENABLE_BIT]
                            & (nxt_state == sleep_seq_pkg::ST_RUN);
      o_precharge_all <= (nxt_state == sleep_seq_pkg::ST_PRECHARGE)
                       & ((nxt_cfg & `CFG_BANK_EN_MASK) != 32'h0);
      // Software command, or sequencer step with banks still live
      o_self_refresh_cmd <= nxt_refr[`REFR_SELF_REFRESH_BIT]
                          | ((nxt_state == sleep_seq_pkg::ST_SELF_REF)
                          & ((nxt_cfg & `CFG_BANK_EN_MASK) != 32'h0));
      o_sleep <= (nxt_state == sleep_seq_pkg::ST_SLEEP);
    end
  end

  // Status flags; a new cause beats a software clear
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_hard_reset_flag       <= 1'b1;
      o_sleep_wake_reset_flag <= 1'b0;
      o_software_sleep_flag   <= 1'b0;
      sw_sleep_ff             <= 1'b0;
    end
    else
    begin
      sw_sleep_ff <= in_sleep & sw_entry_ff;
      if (in_sleep && nxt_state == sleep_seq_pkg::ST_RUN)
      begin
        o_sleep_wake_reset_flag <= 1'b1;
        o_hard_reset_flag       <= 1'b0;
        o_software_sleep_flag   <= sw_entry_ff;
      end
      else if (i_status_clear)
      begin
        o_sleep_wake_reset_flag <= 1'b0;
        o_hard_reset_flag       <= 1'b0;
        o_software_sleep_flag   <= 1'b0;
      end
    end
  end

  // Checks
  property p_fault_sleeps;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == sleep_seq_pkg::ST_RUN && fault_any && !i_access_busy)
      |-> ##[1:8] o_sleep;
  endproperty
  a_fault_sleeps: assert property (p_fault_sleeps)
    else $error("fault did not reach sleep");
  property p_refresh_off;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (o_dram_refresh_control[`REFR_INTERVAL_HI:`REFR_INTERVAL_LO] == 12'h0)
      |-> !o_refresh_enable;
  endproperty
  a_refresh_off: assert property (p_refresh_off)
    else $error("refresh runs with zero interval");
  property p_self_ref;
    @(posedge i_mclk) disable iff (i_sys_rst)
      o_dram_refresh_control[`REFR_SELF_REFRESH_BIT] |-> o_self_refresh_cmd;
  endproperty
  a_self_ref: assert property (p_self_ref)
    else $error("self-refresh bit ignored");
  property p_banks_off;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == sleep_seq_pkg::ST_SLEEP && ce_released
       && (o_dram_config_register & `CFG_BANK_EN_MASK) == 32'h0)
      |-> !o_self_refresh_cmd && !o_precharge_all;
  endproperty
  a_banks_off: assert property (p_banks_off)
    else $error("commands issued to disabled banks");
  property p_cke_low;
    @(posedge i_mclk) disable iff (i_sys_rst)
      !o_dram_refresh_control[`REFR_CLOCK_ENABLE_BIT] |-> !o_sdram_clock_enable;
  endproperty
  a_cke_low: assert property (p_cke_low)
    else $error("clock enable high after release");
  property p_sw_sleep;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == sleep_seq_pkg::ST_RUN && sw_req && !i_access_busy)
      |-> ##[1:8] o_sleep;
  endproperty
  a_sw_sleep: assert property (p_sw_sleep)
    else $error("force sleep not honoured");
  property p_fault_holds;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (o_sleep && fault_any) |=> o_sleep;
  endproperty
  a_fault_holds: assert property (p_fault_holds)
    else $error("left sleep with fault high");
  property p_sw_flag;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $rose(o_software_sleep_flag) |-> $past(sw_sleep_ff);
  endproperty
  a_sw_flag: assert property (p_sw_flag)
    else $error("software flag without software entry");
  property p_flags_apart;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $rose(o_sleep_wake_reset_flag) |-> !o_hard_reset_flag;
  endproperty
  a_flags_apart: assert property (p_flags_apart)
    else $error("both reset causes flagged");
  property p_order;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == sleep_seq_pkg::ST_SELF_REF)
      |-> ($past(state_ff) == sleep_seq_pkg::ST_PRECHARGE);
  endproperty
  a_order: assert property (p_order)
    else $error("self-refresh step not after precharge");
  c_sw_entry: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
    sw_req ##[1:10] o_sleep);
  c_fault_entry: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
    fault_any ##[1:10] o_sleep);
  c_wake: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
    $rose(o_sleep_wake_reset_flag));
endmodule : sdram_sleep_entry_sequencer
`default_nettype wire

// ===== sleep_seq_map.svh
// Bit positions, reset values and sequence constants for sleep entry
`ifndef SLEEP_SEQ_MAP_SVH
`define SLEEP_SEQ_MAP_SVH
`define REFR_SELF_REFRESH_BIT   31
`define REFR_CLOCK_ENABLE_BIT   20
`define REFR_INTERVAL_HI        15
`define REFR_INTERVAL_LO        4
`define CFG_BANK_EN_MASK        32'h0003_0003
`define PMC_FORCE_SLEEP_BIT     0
`define REFR_RESET_VALUE        32'h0010_0000
`define CFG_RESET_VALUE         32'h0000_0000
`define PRECHARGE_CYCLES        4'h3
`endif

// ===== sleep_seq_pkg.sv
// Types shared by the sleep entry sequencer
package sleep_seq_pkg;
  typedef enum logic [2:0] {
    ST_RUN       = 3'b000,
    ST_DRAIN     = 3'b001,
    ST_PRECHARGE = 3'b010,
    ST_SELF_REF  = 3'b011,
    ST_SLEEP     = 3'b100
  } seq_state_t;
endpackage : sleep_seq_pkg

// ===== sync_two_ff.sv
// Two-flop level synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff
(
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_ff;

  // First flop is read only by the second
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      meta_ff <= 1'b0;
      o_sync  <= 1'b0;
    end
    else
    begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end
endmodule : sync_two_ff
`default_nettype wire

// ===== sdram_far_model.sv
// Far-side model: SDRAM bursts and open rows seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module sdram_far_model
(
  input  wire logic       i_mclk,
  input  wire logic       i_burst_go,
  input  wire logic [3:0] i_burst_len,
  input  wire logic       i_precharge_all,
  input  wire logic       i_self_refresh_cmd,
  output logic            o_access_busy,
  output logic            o_order_err
);
  logic [3:0] left_ff = 4'h0;
  logic       row_open_ff = 1'b0;
  logic       err_ff = 1'b0;
  // Burst holds the bus; its row stays open until precharge
  always @(posedge i_mclk)
  begin
    if (i_burst_go) left_ff <= i_burst_len;
    else if (left_ff != 4'h0) left_ff <= left_ff - 4'h1;
    if (i_burst_go) row_open_ff <= 1'b1;
    else if (i_precharge_all) row_open_ff <= 1'b0;
  end
  assign o_access_busy = (left_ff != 4'h0);
  // Self-refresh on a busy bus or open row is illegal, so latch it
  always @(posedge i_mclk)
    if (i_self_refresh_cmd && (o_access_busy || row_open_ff))
      err_ff <= 1'b1;
  assign o_order_err = err_ff;
endmodule : sdram_far_model
`default_nettype wire

// ===== sdram_sleep_entry_sequencer_test.sv
// Self-checking bench for the sleep entry sequencer
`timescale 1ns/1ps
`default_nettype none
module sdram_sleep_entry_sequencer_test;
  logic        i_mclk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [2:0]  we = 3'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [1:0]  fault = 2'h0;
  logic        wake = 1'b0, clr = 1'b0, go = 1'b0;
  logic [3:0]  len = 4'h0;
  wire  logic  busy, err, ref_en, cke, pre, sref, slp, sw, hw, sleep_wake_reset_flag;
  wire  logic [31:0] refr, cfg;
  int          fails = 0;
  int          cmp_count = 0;

  always #10 i_mclk = ~i_mclk;

  sdram_sleep_entry_sequencer dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_refr_we(we[0]), .i_refr_wdata(wdata), .i_cfg_we(we[1]),
    .i_cfg_wdata(wdata), .i_pmc_we(we[2]), .i_pmc_wdata(wdata),
    .i_battery_fault_input(fault[0]), .i_supply_fault_input(fault[1]),
    .i_access_busy(busy), .i_wake(wake), .i_status_clear(clr),
    .o_dram_refresh_control(refr), .o_dram_config_register(cfg),
    .o_refresh_enable(ref_en), .o_sdram_clock_enable(cke),
    .o_precharge_all(pre), .o_self_refresh_cmd(sref), .o_sleep(slp),
    .o_software_sleep_flag(sw), .o_hard_reset_flag(hw),
    .o_sleep_wake_reset_flag(sleep_wake_reset_flag));

  sdram_far_model far_u (.i_mclk(i_mclk), .i_burst_go(go),
    .i_burst_len(len), .i_precharge_all(pre), .i_self_refresh_cmd(sref),
    .o_access_busy(busy), .o_order_err(err));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // One whole 32-bit write; outputs looked at one cycle after the take
  task automatic wr(input int sel, input logic [31:0] d);
    @(negedge i_mclk);
    wdata = d;
    we = 3'(1 << sel);
    @(negedge i_mclk);
    we = 3'h0;
    @(negedge i_mclk);
  endtask : wr

  task automatic pulse_wake();
    @(negedge i_mclk);
    wake = 1'b1;
    @(negedge i_mclk);
    wake = 1'b0;
    @(negedge i_mclk);
  endtask : pulse_wake

  // Bounded wait on the sleep output
  task automatic wait_sleep(input logic exp, input int bound);
    for (int n = 0; n < bound && slp !== exp; n++) @(negedge i_mclk);
    check("sleep wait", 32'(slp), 32'(exp));
    if (slp !== exp) close_out();
  endtask : wait_sleep

  task automatic t_reset();
    check("refr reset", refr, 32'h0010_0000);
    check("cfg reset", cfg, 32'h0000_0000);
    check("flags reset", {29'h0, sw, hw, sleep_wake_reset_flag}, 32'h0000_0002);
  endtask : t_reset

  task automatic t_soft();
    go = 1'b0; // No far-model burst traffic during the sequence
    wr(0, 32'h0010_0FF0);
    check("refresh on", 32'(ref_en), 32'h1);
    wr(0, 32'h0010_0000);
    check("refresh off", 32'(ref_en), 32'h0);
    wr(0, 32'h8010_0000);
    check("self ref cmd", {sref, refr[30:0]}, 32'h8010_0000);
    wr(1, 32'h0003_0F03);
    wr(1, 32'h0000_0F00);
    check("banks off", cfg, 32'h0000_0F00);
    wr(0, 32'h0000_0000);
    check("cke sref off", {30'h0, cke, sref}, 32'h0);
    wr(2, 32'h0000_0001);
    check("not yet asleep", 32'(slp), 32'h0);
    wait_sleep(1'b1, 12);
    pulse_wake();
    check("soft wake", {29'h0, sw, hw, sleep_wake_reset_flag}, 32'h0000_0005);
  endtask : t_soft

  // Each fault input alone enters sleep and holds it while high
  task automatic t_fault();
    for (int k = 0; k < 2; k++)
    begin
      fault = 2'(1 << k);
      wait_sleep(1'b1, 14);
      pulse_wake();
      check("held by fault", 32'(slp), 32'h1);
      fault = 2'h0;
      repeat (4) @(negedge i_mclk);
      pulse_wake();
      wait_sleep(1'b0, 4);
      check("fault wake", {30'h0, sw, sleep_wake_reset_flag}, 32'h1);
    end
  endtask : t_fault

  // Sleep asked during a burst with banks on: drain, precharge, then sref
  task automatic t_drain();
    wr(1, 32'h0003_0003);
    @(negedge i_mclk);
    len = 4'h6;
    go = 1'b1;
    // Burst already running when force sleep arrives
    @(negedge i_mclk);
    go = 1'b0;
    wdata = 32'h0000_0001;
    we = 3'h4;
    @(negedge i_mclk);
    we = 3'h0;
    repeat (5) @(negedge i_mclk);
    check("asleep in burst", 32'(slp), 32'h0);
    wait_sleep(1'b1, 20);
    check("order err", 32'(err), 32'h0);
    pulse_wake();
    check("sw flag", 32'(sw), 32'h1);
    @(negedge i_mclk);
    clr = 1'b1;
    @(negedge i_mclk);
    clr = 1'b0;
    @(negedge i_mclk);
    check("cleared", {29'h0, sw, hw, sleep_wake_reset_flag}, 32'h0);
  endtask : t_drain

  // Hard reset in mid-run brings back reset values and the hard flag
  task automatic t_midreset();
    @(negedge i_mclk);
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    t_reset();
  endtask : t_midreset

  initial
  begin
    repeat (20) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    t_reset();
    t_soft();
    t_fault();
    t_drain();
    t_midreset();
    close_out();
  end
endmodule : sdram_sleep_entry_sequencer_test
`default_nettype wire
